// ---- rtl/ubr_regs.svh ----
`ifndef UBR_REGS_SVH
`define UBR_REGS_SVH

// Register byte offsets
`define UBR_OFS_STATUS   8'h00
`define UBR_OFS_CTRL1    8'h04
`define UBR_OFS_CTRL2    8'h08
`define UBR_OFS_BAUD     8'h0c
`define UBR_OFS_DATA     8'h10
`define UBR_OFS_COUNT    8'h14

// Control register one fields
`define UBR_C1_UART_EN   0
`define UBR_C1_RX_EN     1
`define UBR_C1_WORD9     2
`define UBR_C1_PAR_EN    3
`define UBR_C1_PTYPE_LO  4
`define UBR_C1_STOP2     6
`define UBR_C1_BRK_REQ   7
`define UBR_C1_RX8       8

// Control register two fields
`define UBR_C2_RIE       0
`define UBR_C2_TRIG_LO   1

// Status register fields
`define UBR_SR_RXIF      0
`define UBR_SR_OERR      1
`define UBR_SR_NOISE     2
`define UBR_SR_FERR      3
`define UBR_SR_PERR      4
`define UBR_SR_RIDLE     5
`define UBR_SR_TIDLE     6

// Reset values
`define UBR_RST_CTRL1    8'h00
`define UBR_RST_CTRL2    3'h0
`define UBR_RST_BAUD     16'h0000

// Timing counts and receive buffer depth
`define UBR_OVS_LAST     4'hf
`define UBR_SMP_A        4'h7
`define UBR_SMP_B        4'h8
`define UBR_SMP_C        4'h9
`define UBR_BRK_LAST     4'hc
`define UBR_FIFO_DEPTH   3'h4

`endif

// ---- rtl/ubr_pkg.sv ----
package ubr_pkg;
  typedef enum logic [1:0] {
    UBR_TX_IDLE  = 2'b00,
    UBR_TX_START = 2'b01,
    UBR_TX_BRK   = 2'b10,
    UBR_TX_STOP  = 2'b11
  } ubr_tx_state_t;

  typedef enum logic [2:0] {
    UBR_RX_HUNT  = 3'b000,
    UBR_RX_START = 3'b001,
    UBR_RX_DATA  = 3'b010,
    UBR_RX_STOP  = 3'b011,
    UBR_RX_STOP2 = 3'b100,
    UBR_RX_WAITH = 3'b101
  } ubr_rx_state_t;

  typedef logic [15:0] ubr_word_t;
  typedef logic [10:0] ubr_entry_t;
endpackage

// ---- rtl/ubr_fifo_mem.sv ----
`timescale 1ns/1ps
module ubr_fifo_mem (
  input  wire logic              i_clk,
  input  wire logic              i_we,
  input  wire logic [1:0]        i_waddr,
  input  wire ubr_pkg::ubr_entry_t i_wdata,
  input  wire logic [1:0]        i_raddr,
  output ubr_pkg::ubr_entry_t    o_rdata
);
  import ubr_pkg::*;

  ubr_entry_t mem_r [4];
  ubr_entry_t q_r;

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  // Write-through keeps the head word fresh when a word lands in an empty buffer
  always_ff @(posedge i_clk) begin
    if (i_we && (i_waddr == i_raddr)) begin
      q_r <= i_wdata;
    end else begin
      q_r <= mem_r[i_raddr];
    end
  end

  assign o_rdata = q_r;
endmodule // ubr_fifo_mem

// ---- rtl/ubr_top.sv ----
// Summary of operation
// - Break request held over divisor-plus-one clocks while transmitter idle starts break.
// - Break is start bit, then thirteen-times-N low bits, then stop bits.
// - Sending break never raises a transmit interrupt.
// - Break repeats while requested; after clear, finish character then one or two stops.
// - Receive 8 or 9 bit words; ninth bit readable in control register one.
// - Recovery runs at sixteen times baud; shift register advances once per bit.
// - Each bit level is the majority of three pin samples.
// - Serial data shifts in least significant bit first.
// - After stop sample, completed word moves into the buffer if room.
// - Buffer holds four words while a fifth shifts; read via shared data register.
// - Setting receive enable starts start-bit hunting.
// - Data-available flag while buffer non-empty; count readable.
// - Interrupt when enabled and fill reaches trigger level, or on overrun.
// - Overrun, noise flags clear after status access then data read, or on UART disable; available clears when buffer empties.
// - Fifth word into full buffer sets overrun, keeps buffer, discards word.
// - Break ends as framing error with zero data, data-available and idle set.
// - After break, wait for high line before hunting for next start.
// - Receiver-idle low from start detect to stop read, high otherwise.
// - Noise sets noise flag with the word push, no extra interrupt.
// - Low stop bit sets framing error, both checked with two stops; stored per word.
// - Parity error only for enabled odd or even parity; stored per word.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "ubr_regs.svh"
module ubr_top (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic [7:0]       i_addr,
  input  wire ubr_pkg::ubr_word_t i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output ubr_pkg::ubr_word_t    o_rdata,
  input  wire logic             i_rx,
  output logic                  o_tx,
  output logic                  o_irq
);
  import ubr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [3:0] inc4(input logic [3:0] v);
    inc4 = v + 4'h1;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [7:0]    ctrl1_r;
  logic [2:0]    ctrl2_r;
  logic [15:0]   baud_r;
  logic          oerr_r;
  logic          noise_r;
  logic          stat_seen_r;
  ubr_word_t     rdata_r;
  logic          irq_r;
  logic          tx_r;

  wire uart_en   = ctrl1_r[`UBR_C1_UART_EN];
  wire rx_en     = ctrl1_r[`UBR_C1_RX_EN];
  wire word9     = ctrl1_r[`UBR_C1_WORD9];
  wire par_en    = ctrl1_r[`UBR_C1_PAR_EN];
  wire [1:0] ptype = ctrl1_r[`UBR_C1_PTYPE_LO +: 2];
  wire stop2     = ctrl1_r[`UBR_C1_STOP2];
  wire brk_req   = ctrl1_r[`UBR_C1_BRK_REQ];
  wire rie       = ctrl2_r[`UBR_C2_RIE];
  wire [1:0] trig = ctrl2_r[`UBR_C2_TRIG_LO +: 2];

  wire sel_stat  = (i_addr == `UBR_OFS_STATUS);
  wire sel_c1    = (i_addr == `UBR_OFS_CTRL1);
  wire sel_c2    = (i_addr == `UBR_OFS_CTRL2);
  wire sel_baud  = (i_addr == `UBR_OFS_BAUD);
  wire sel_data  = (i_addr == `UBR_OFS_DATA);
  wire sel_cnt   = (i_addr == `UBR_OFS_COUNT);
  wire stat_rd   = i_rd && sel_stat;
  wire data_rd   = i_rd && sel_data;

  //////////////////////////////////////////////////////////////////////////////
  // Receive buffer

  logic [1:0] head_r;
  logic [1:0] tail_r;
  logic [2:0] count_r;
  ubr_entry_t head_q;
  ubr_entry_t push_word;
  logic       push;

  wire fifo_full  = (count_r == `UBR_FIFO_DEPTH);
  wire fifo_empty = (count_r == 3'h0);
  wire do_push    = push && !fifo_full;
  wire do_pop     = data_rd && !fifo_empty;
  wire [1:0] head_nxt = uart_en ? head_r + {1'b0, do_pop} : 2'h0;  // Head fresh after a pop
  wire overrun    = push && fifo_full;

  ubr_fifo_mem u_mem (
    .i_clk   (i_clk),
    .i_we    (do_push),
    .i_waddr (tail_r),
    .i_wdata (push_word),
    .i_raddr (head_nxt),
    .o_rdata (head_q)
  );

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      head_r  <= 2'h0;
      tail_r  <= 2'h0;
      count_r <= 3'h0;
    end else if (!uart_en) begin
      head_r  <= 2'h0;
      tail_r  <= 2'h0;
      count_r <= 3'h0;
    end else begin
      if (do_push) tail_r <= tail_r + 2'h1;
      head_r <= head_nxt;
      count_r <= count_r + {2'h0, do_push} - {2'h0, do_pop};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Oversampling tick, sixteen per bit time

  logic [15:0] bd_cnt_r;
  wire tick = uart_en && (bd_cnt_r == baud_r);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) bd_cnt_r <= 16'h0000;
    else if (!uart_en || tick) bd_cnt_r <= 16'h0000;
    else bd_cnt_r <= bd_cnt_r + 16'h0001;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Break transmitter

  ubr_tx_state_t tx_st_r;
  logic [3:0]    tx_os_r;
  logic [3:0]    tx_bit_r;
  logic [16:0]   hold_r;
  wire tx_idle   = (tx_st_r == UBR_TX_IDLE);
  wire brk_armed = (hold_r == ({1'b0, baud_r} + 17'h00001));
  wire tx_bitend = tick && (tx_os_r == `UBR_OVS_LAST);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) hold_r <= 17'h00000;
    else if (!(uart_en && brk_req && tx_idle)) hold_r <= 17'h00000;
    else if (!brk_armed) hold_r <= hold_r + 17'h00001;
  end

  // No transmit flag is touched here, so break frames raise no interrupt.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_st_r  <= UBR_TX_IDLE;
      tx_os_r  <= 4'h0;
      tx_bit_r <= 4'h0;
      tx_r     <= 1'b1;
    end else if (!uart_en) begin
      tx_st_r  <= UBR_TX_IDLE;
      tx_r     <= 1'b1;
    end else begin
      if (tick) tx_os_r <= inc4(tx_os_r);
      unique case (tx_st_r)
        UBR_TX_IDLE: begin
          tx_r <= 1'b1;
          if (brk_armed && tick) begin  // Tick-aligned so the start bit is full length
            tx_st_r <= UBR_TX_START;
            tx_os_r <= 4'h0;
            tx_r    <= 1'b0;
          end
        end
        UBR_TX_START: begin
          if (tx_bitend) begin
            tx_st_r  <= UBR_TX_BRK;
            tx_bit_r <= 4'h0;
          end
        end
        UBR_TX_BRK: begin
          if (tx_bitend) begin
            tx_bit_r <= inc4(tx_bit_r);
            if (tx_bit_r == `UBR_BRK_LAST) begin
              tx_bit_r <= 4'h0;
              if (!brk_req) begin
                tx_st_r <= UBR_TX_STOP;
                tx_r    <= 1'b1;
              end
            end
          end
        end
        UBR_TX_STOP: begin
          if (tx_bitend) begin
            tx_bit_r <= inc4(tx_bit_r);
            if (tx_bit_r == {3'h0, stop2}) tx_st_r <= UBR_TX_IDLE;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receiver

  logic          rx_m_r;
  logic          rx_s_r;
  logic          rx_p_r;
  ubr_rx_state_t rx_st_r;
  logic [3:0]    rx_os_r;
  logic [3:0]    rx_bit_r;
  logic [1:0]    smp_r;
  logic [8:0]    shreg_r;
  logic          frm_noise_r;
  logic          stop_ok_r;

  wire rx_fall   = rx_p_r && !rx_s_r;
  wire bit_dec   = tick && (rx_os_r == `UBR_SMP_C);
  wire maj       = maj3(smp_r[0], smp_r[1], rx_s_r);
  wire smp_noise = !((smp_r[0] == smp_r[1]) && (smp_r[1] == rx_s_r));
  wire [3:0] nbits = word9 ? 4'h9 : 4'h8;
  wire [8:0] word  = word9 ? shreg_r : {1'b0, shreg_r[8:1]};
  wire par_bad   = par_en && !ptype[1] && ((^word) != ptype[0]);
  wire ridle     = (rx_st_r == UBR_RX_HUNT) || (rx_st_r == UBR_RX_WAITH);
  wire stop_bad  = !maj || (rx_st_r == UBR_RX_STOP2 && !stop_ok_r);
  wire last_stop = bit_dec && ((rx_st_r == UBR_RX_STOP2) ||
                               (rx_st_r == UBR_RX_STOP && !stop2));

  assign push      = last_stop;
  assign push_word = {par_bad, stop_bad, word};

  // Only the second and third stages feed logic; the first stage settles metastability
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
      rx_p_r <= 1'b1;
    end else begin
      rx_m_r <= i_rx;
      rx_s_r <= rx_m_r;
      rx_p_r <= rx_s_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_st_r     <= UBR_RX_HUNT;
      rx_os_r     <= 4'h0;
      rx_bit_r    <= 4'h0;
      smp_r       <= 2'h0;
      shreg_r     <= 9'h000;
      frm_noise_r <= 1'b0;
      stop_ok_r   <= 1'b0;
    end else if (!uart_en || !rx_en) begin
      rx_st_r <= UBR_RX_HUNT;
    end else begin
      if (tick) rx_os_r <= inc4(rx_os_r);
      if (tick && rx_os_r == `UBR_SMP_A) smp_r[0] <= rx_s_r;
      if (tick && rx_os_r == `UBR_SMP_B) smp_r[1] <= rx_s_r;
      if (bit_dec && rx_st_r != UBR_RX_HUNT && rx_st_r != UBR_RX_WAITH)
        frm_noise_r <= frm_noise_r | smp_noise;
      unique case (rx_st_r)
        UBR_RX_HUNT: begin
          if (rx_fall) begin
            rx_st_r     <= UBR_RX_START;
            rx_os_r     <= 4'h0;
            frm_noise_r <= 1'b0;
          end
        end
        UBR_RX_START: begin
          if (bit_dec) begin
            rx_bit_r <= 4'h0;
            rx_st_r  <= maj ? UBR_RX_HUNT : UBR_RX_DATA;
          end
        end
        UBR_RX_DATA: begin
          if (bit_dec) begin
            shreg_r  <= {maj, shreg_r[8:1]};
            rx_bit_r <= inc4(rx_bit_r);
            if (inc4(rx_bit_r) == nbits) rx_st_r <= UBR_RX_STOP;
          end
        end
        UBR_RX_STOP: begin
          if (bit_dec) begin
            stop_ok_r <= maj;
            if (stop2) rx_st_r <= UBR_RX_STOP2;
            else rx_st_r <= maj ? UBR_RX_HUNT : UBR_RX_WAITH;
          end
        end
        UBR_RX_STOP2: begin
          if (bit_dec) rx_st_r <= maj ? UBR_RX_HUNT : UBR_RX_WAITH;
        end
        UBR_RX_WAITH: begin
          // A held-low line after a break must never count as a new start
          if (rx_s_r) rx_st_r <= UBR_RX_HUNT;
        end
        default: rx_st_r <= UBR_RX_HUNT;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags and software access

  wire flag_clr = data_rd && stat_seen_r;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      oerr_r      <= 1'b0;
      noise_r     <= 1'b0;
      stat_seen_r <= 1'b0;
    end else if (!uart_en) begin
      oerr_r      <= 1'b0;
      noise_r     <= 1'b0;
      stat_seen_r <= 1'b0;
    end else begin
      if (stat_rd) stat_seen_r <= 1'b1;
      else if (data_rd) stat_seen_r <= 1'b0;
      // A new event in the clearing cycle wins
      oerr_r  <= overrun | (oerr_r & !flag_clr);
      noise_r <= (do_push & (frm_noise_r | smp_noise)) | (noise_r & !flag_clr);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl1_r <= `UBR_RST_CTRL1;
      ctrl2_r <= `UBR_RST_CTRL2;
      baud_r  <= `UBR_RST_BAUD;
    end else if (i_wr) begin
      if (sel_c1) begin
        ctrl1_r <= i_wdata[7:0];
        // Disabling clears receive enable and break request with it
        if (!i_wdata[`UBR_C1_UART_EN]) begin
          ctrl1_r[`UBR_C1_RX_EN]   <= 1'b0;
          ctrl1_r[`UBR_C1_BRK_REQ] <= 1'b0;
        end
      end
      if (sel_c2) ctrl2_r <= i_wdata[2:0];
      if (sel_baud) baud_r <= i_wdata;
    end
  end

  wire rxif = !fifo_empty;
  wire [15:0] stat_val = {9'h000, !tx_idle ? 1'b0 : 1'b1, ridle,
                          head_q[10] & rxif, head_q[9] & rxif,
                          noise_r, oerr_r, rxif};
  wire [15:0] c1_val   = {7'h00, head_q[8] & word9 & rxif, ctrl1_r};
  wire [15:0] rd_mux   = sel_stat ? stat_val :
                         sel_c1   ? c1_val :
                         sel_c2   ? {13'h0000, ctrl2_r} :
                         sel_baud ? baud_r :
                         sel_data ? (rxif ? {8'h00, head_q[7:0]} : 16'h0000) :
                         sel_cnt  ? {13'h0000, count_r} : 16'h0000;
  wire trig_hit = (count_r >= ({1'b0, trig} + 3'h1));

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_r <= 16'h0000;
      irq_r   <= 1'b0;
    end else begin
      rdata_r <= i_rd ? rd_mux : 16'h0000;
      irq_r   <= uart_en && rie && (trig_hit || oerr_r);
    end
  end

  assign o_rdata = rdata_r;
  assign o_irq   = irq_r;
  assign o_tx    = tx_r;
endmodule // ubr_top

// ---- verification/ubr_top_asserts.sv ----
`timescale 1ns/1ps
`include "ubr_regs.svh"
module ubr_top_checker (
  input wire logic               i_clk,
  input wire logic               i_rstn,
  input wire logic [7:0]         i_addr,
  input wire ubr_pkg::ubr_word_t i_wdata,
  input wire logic               i_wr,
  input wire logic               i_rd,
  input wire ubr_pkg::ubr_word_t o_rdata,
  input wire logic               i_rx,
  input wire logic               o_tx,
  input wire logic               o_irq
);
  import ubr_pkg::*;
  logic        brk_r, rie_r, rd_any_r, rd_data_r, rd_cnt_r;
  logic [15:0] baud_r;
  int          low_cnt_r, clr_cnt_r, bit_clks;
  assign bit_clks = 16 * (int'(baud_r) + 1);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////
  // Shadow copies of the control fields from the write traffic, and read strobes delayed one cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {brk_r, rie_r, rd_any_r, rd_data_r, rd_cnt_r} <= 5'h00;
      baud_r <= 16'h0000;
    end else begin
      if (i_wr && i_addr == `UBR_OFS_CTRL1) brk_r <= i_wdata[7] & i_wdata[0];
      if (i_wr && i_addr == `UBR_OFS_CTRL2) rie_r <= i_wdata[0];
      if (i_wr && i_addr == `UBR_OFS_BAUD) baud_r <= i_wdata;
      rd_any_r <= i_rd;
      rd_data_r <= i_rd && i_addr == `UBR_OFS_DATA;
      rd_cnt_r <= i_rd && i_addr == `UBR_OFS_COUNT;
    end
  end
  // Counters of low line time: whole break, and the part after the request drops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      low_cnt_r <= 0;
      clr_cnt_r <= 0;
    end else begin
      low_cnt_r <= o_tx ? 0 : low_cnt_r + 1;
      clr_cnt_r <= (o_tx || brk_r) ? 0 : clr_cnt_r + 1;
    end
  end
  ////////////////////////////////////////
  sequence stop_hold_s;
    o_tx [*8];
  endsequence
  brk_cause_a: assert property ($fell(o_tx) |-> $past(brk_r))
    else $error("tx went low without a break request");
  brk_length_a: assert property ($rose(o_tx) |-> low_cnt_r >= 14 * bit_clks &&
    (low_cnt_r - bit_clks) % (13 * bit_clks) == 0)
    else $error("break low time not start plus thirteen times N bits");
  brk_repeat_a: assert property (brk_r && !o_tx |=> !o_tx)
    else $error("break ended while still requested");
  brk_finish_a: assert property (clr_cnt_r <= 14 * bit_clks)
    else $error("break ran on after request cleared");
  stop_bits_a: assert property ($rose(o_tx) |-> stop_hold_s)
    else $error("no stop level after break");
  irq_gate_a: assert property (!rie_r && !$past(rie_r) |-> !o_irq)
    else $error("interrupt without receive interrupt enable");
  rdata_quiet_a: assert property (!rd_any_r |-> o_rdata == 16'h0000)
    else $error("read data outside read answer cycle");
  data_width_a: assert property (rd_data_r |-> o_rdata[15:8] == 8'h00)
    else $error("data register upper byte not zero");
  count_limit_a: assert property (rd_cnt_r |-> o_rdata <= 16'h0004)
    else $error("receive count above four");
endmodule // ubr_top_checker

bind ubr_top ubr_top_checker i_ubr_top_checker (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr,
  .i_rd, .o_rdata, .i_rx, .o_tx, .o_irq);

// ---- verification/ubr_line_model.sv ----
`timescale 1ns/1ps
module ubr_line_model (
  input  wire logic i_clk,
  output logic      o_line
);
  int bit_clks = 32;
  initial o_line = 1'b1;
  // A two-clock flip mid-bit hits exactly one of three samples at divisor one
  task automatic drive_bit(input logic val, input logic glitch);
    for (int c = 0; c < bit_clks; c++) begin
      @(posedge i_clk);
      o_line <= (glitch && (c == 18 || c == 19)) ? ~val : val;
    end
  endtask
  // Line keeps the last bit afterwards, so a low stop leaves it held low
  task automatic send(input logic [11:0] bits, input int n, input logic noisy);
    drive_bit(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      drive_bit(bits[i], noisy && (i == 0));
    end
  endtask
endmodule // ubr_line_model

// ---- verification/ubr_top_bench.sv ----
`timescale 1ns/1ps
`include "ubr_regs.svh"
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp); end end
module ubr_top_bench;
  import ubr_pkg::*;
  logic       i_clk, i_rstn, i_wr, i_rd, o_tx, o_irq;
  logic [7:0] i_addr;
  ubr_word_t  i_wdata, o_rdata;
  wire        rx_line;
  int         err_total, total_checks, cycles, lowc;
  logic [7:0] pat [5] = '{8'h01, 8'h80, 8'h3c, 8'hc3, 8'hff};
  ubr_top i_ubr_top (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_rx(rx_line), .o_tx, .o_irq);
  ubr_line_model i_ubr_line_model (.i_clk, .o_line(rx_line));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  ////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      $display("MISMATCH %0t run too long", $time);
      summarize();
    end
  end
  task automatic wr(input logic [7:0] a, input ubr_word_t d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input ubr_word_t m, input ubr_word_t e);
    ubr_word_t v;
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
    `CHK(v & m, e, $sformatf("read %h", a))
  endtask
  task automatic rx8(input logic [7:0] d);
    i_ubr_line_model.send({4'b0001, d}, 9, 1'b0);
    repeat (4) @(posedge i_clk);
  endtask
  ////////////////////////////////////////
  initial begin
    {i_rstn, i_wr, i_rd, i_addr, i_wdata} = '0;
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    chk_rd(`UBR_OFS_CTRL1, 16'hffff, 16'h0000);
    chk_rd(`UBR_OFS_CTRL2, 16'hffff, 16'h0000);
    wr(8'h18, 16'hffff);
    chk_rd(8'h18, 16'hffff, 16'h0000);
    wr(`UBR_OFS_BAUD, 16'h0001);
    chk_rd(`UBR_OFS_BAUD, 16'hffff, 16'h0001);
    wr(`UBR_OFS_CTRL1, 16'h0001);
    rx8(8'h55);
    chk_rd(`UBR_OFS_COUNT, 16'hffff, 16'h0000);
    $display("test registers done");
    // Fill to the trigger, then overrun; no status read yet, so overrun must stay
    wr(`UBR_OFS_CTRL1, 16'h0003);
    wr(`UBR_OFS_CTRL2, 16'h0007);
    for (int i = 0; i < 5; i++) begin
      rx8(pat[i]);
      `CHK(o_irq, (i >= 3) ? 1'b1 : 1'b0, "fill interrupt")
    end
    for (int i = 0; i < 3; i++) chk_rd(`UBR_OFS_DATA, 16'hffff, {8'h00, pat[i]});
    chk_rd(`UBR_OFS_COUNT, 16'hffff, 16'h0001);
    `CHK(o_irq, 1'b1, "overrun interrupt")
    chk_rd(`UBR_OFS_STATUS, 16'h0003, 16'h0003);
    chk_rd(`UBR_OFS_DATA, 16'hffff, 16'h00c3);
    chk_rd(`UBR_OFS_STATUS, 16'h0003, 16'h0000);
    `CHK(o_irq, 1'b0, "interrupt after drain")
    $display("test buffer done");
    wr(`UBR_OFS_CTRL2, 16'h0000);
    i_ubr_line_model.drive_bit(1'b1, 1'b1);
    // Idle after the glitch, so the mid-bit confirmation sees a high line
    i_ubr_line_model.drive_bit(1'b1, 1'b0);
    chk_rd(`UBR_OFS_STATUS, 16'h0021, 16'h0020);
    fork
      i_ubr_line_model.send(12'h194, 9, 1'b0);
      begin
        repeat (100) @(posedge i_clk);
        chk_rd(`UBR_OFS_STATUS, 16'h0020, 16'h0000);
      end
    join
    repeat (4) @(posedge i_clk);
    chk_rd(`UBR_OFS_DATA, 16'hffff, 16'h0094);
    i_ubr_line_model.send(12'h16b, 9, 1'b1);
    repeat (4) @(posedge i_clk);
    chk_rd(`UBR_OFS_DATA, 16'hffff, 16'h006b);
    chk_rd(`UBR_OFS_STATUS, 16'h0004, 16'h0004);
    chk_rd(`UBR_OFS_DATA, 16'hffff, 16'h0000);
    chk_rd(`UBR_OFS_STATUS, 16'h0025, 16'h0020);
    $display("test noise done");
    for (int t = 0; t < 4; t++) begin
      wr(`UBR_OFS_CTRL1, 16'h000f | 16'(t << 4));
      i_ubr_line_model.send(12'h335, 10, 1'b0);
      repeat (4) @(posedge i_clk);
      chk_rd(`UBR_OFS_STATUS, 16'h0010, (t == 0) ? 16'h0010 : 16'h0000);
      chk_rd(`UBR_OFS_CTRL1, 16'h0100, 16'h0100);
      chk_rd(`UBR_OFS_DATA, 16'hffff, 16'h0035);
    end
    wr(`UBR_OFS_CTRL1, 16'h0043);
    i_ubr_line_model.send(12'h15a, 10, 1'b0);
    i_ubr_line_model.drive_bit(1'b1, 1'b0);
    chk_rd(`UBR_OFS_STATUS, 16'h0009, 16'h0009);
    chk_rd(`UBR_OFS_DATA, 16'hffff, 16'h005a);
    $display("test format done");
    wr(`UBR_OFS_CTRL1, 16'h0003);
    i_ubr_line_model.send(12'h000, 9, 1'b0);
    repeat (6) i_ubr_line_model.drive_bit(1'b0, 1'b0);
    chk_rd(`UBR_OFS_STATUS, 16'h0029, 16'h0029);
    chk_rd(`UBR_OFS_COUNT, 16'hffff, 16'h0001);
    i_ubr_line_model.drive_bit(1'b1, 1'b0);
    rx8(8'h96);
    chk_rd(`UBR_OFS_DATA, 16'hffff, 16'h0000);
    chk_rd(`UBR_OFS_DATA, 16'hffff, 16'h0096);
    $display("test break receive done");
    // Divisor three makes a bit 64 clocks and needs the request held four clocks, so a two-clock request is clearly too short
    wr(`UBR_OFS_BAUD, 16'h0003);
    wr(`UBR_OFS_CTRL2, 16'h0001);
    wr(`UBR_OFS_CTRL1, 16'h0081);
    wr(`UBR_OFS_CTRL1, 16'h0001);
    repeat (20) @(posedge i_clk);
    `CHK(o_tx, 1'b1, "short break request")
    wr(`UBR_OFS_CTRL1, 16'h0081);
    for (int n = 0; n < 20 && o_tx; n++) @(posedge i_clk);
    `CHK(o_tx, 1'b0, "break start")
    lowc = 0;
    fork
      begin
        repeat (1000) @(posedge i_clk);
        wr(`UBR_OFS_CTRL1, 16'h0001);
      end
      while (o_tx !== 1'b1 && lowc < 4000) begin
        @(posedge i_clk);
        lowc++;
      end
    join
    `CHK((lowc + 32) / 64, 27, "break bit count")
    `CHK(o_irq, 1'b0, "interrupt from break")
    repeat (60) @(posedge i_clk);
    `CHK(o_tx, 1'b1, "stop after break")
    $display("test break transmit done");
    summarize();
  end
endmodule // ubr_top_bench
